// File: hw/table_map_pkg.sv
package table_map_pkg;
	// ========================================
	// widths and vectors
	localparam int          PC_W        = 11;
	localparam int          WORD_W      = 15;
	localparam int          DATA_W      = 8;
	localparam logic [10:0] RESET_VEC   = 11'h000;
	localparam logic [10:0] TIMER_VEC   = 11'h008;
	localparam logic [2:0]  LAST_PAGE   = 3'h7;
	// ========================================
	// data memory map
	localparam logic [7:0]  ADDR_IND        = 8'h00;
	localparam logic [7:0]  ADDR_MEM_PTR    = 8'h01;
	localparam logic [7:0]  ADDR_PCL        = 8'h02;
	localparam logic [7:0]  ADDR_TABLE_PTR  = 8'h07;
	localparam logic [7:0]  ADDR_TABLE_HIGH = 8'h08;
	localparam logic [7:0]  ADDR_PAGE_PTR   = 8'h1f;
	localparam logic [7:0]  GPR_BASE        = 8'h20;
	localparam int          GPR_DEPTH       = 96;
	localparam logic [7:0]  RESET_BYTE      = 8'h00;
	localparam logic [2:0]  STACK_DEPTH     = 3'h4;

	// ========================================
	// core operations seen by this block
	typedef enum logic [4:0] {
		OP_NONE  = 5'b00001,
		OP_READ  = 5'b00010,
		OP_WRITE = 5'b00100,
		OP_BIT   = 5'b01000,
		OP_TABLE = 5'b10000
	} op_t;

	typedef enum logic [2:0] {
		ST_FETCH = 3'b001,
		ST_TABLE = 3'b010,
		ST_VEC   = 3'b100
	} phase_t;

	typedef struct packed {
		op_t        op;
		logic [7:0] addr;
		logic [7:0] wdata;
		logic [2:0] bit_sel;
		logic       bit_val;
		logic       last_page;
	} req_t;
endpackage : table_map_pkg

// File: hw/table_map.sv
`timescale 1ns/10ps
`default_nettype none
module table_map
	import table_map_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              reset_i,
	input  wire table_map_pkg::req_t req_i,
	input  wire logic              page_opt_i,
	input  wire logic              timer_ovf_i,
	input  wire logic              timer_irq_en_i,
	input  wire logic [2:0]        stack_level_i,
	input  wire logic [14:0]       rom_data_i,
	output logic [10:0]            rom_addr_o,
	output logic [10:0]            pc_o,
	output logic [7:0]             rdata_o,
	output logic                   busy_o,
	output logic                   vector_o
);
	// ========================================
	// state
	// every register of the block lives here, so reset and next state stay in step
	typedef struct packed {
		phase_t                    phase;
		logic [10:0]               pc;
		logic [10:0]               rom_addr;
		logic [7:0]                mem_pointer;
		logic [7:0]                table_pointer;
		logic [7:0]                table_high_byte;
		logic [7:0]                table_page_pointer;
		logic [7:0]                dest;
		logic [7:0]                rdata;
		logic                      busy;
		logic                      vector;
		logic [GPR_DEPTH-1:0][7:0] ram;
	} state_t;

	state_t s;
	state_t next_s;

	// ========================================
	// helpers
	// effective address: indirect port goes through the pointer
	function automatic logic [7:0] eff(input logic [7:0] a, input logic [7:0] p);
		eff = (a == ADDR_IND) ? p : a;
	endfunction : eff

	// general ram window; everything above it is unused space
	function automatic logic is_gpr(input logic [7:0] a);
		is_gpr = (a >= GPR_BASE) && (a < GPR_BASE + 8'(GPR_DEPTH));
	endfunction : is_gpr

	// ram index; only meaningful where is_gpr holds
	function automatic logic [6:0] gpr_index(input logic [7:0] a);
		gpr_index = 7'(a - GPR_BASE);
	endfunction : gpr_index

	// vector only with the enable set and room left on the stack
	function automatic logic vector_taken(input logic ovf, input logic en, input logic [2:0] lvl);
		vector_taken = ovf && en && (lvl < STACK_DEPTH);
	endfunction : vector_taken

	// combinational helpers of the next-state process
	logic [7:0]  ea;
	logic [6:0]  ri;
	logic [7:0]  cur;
	logic [7:0]  wv;
	logic [10:0] taddr;

	// ========================================
	// read mux, write path, table sequencing
	always_comb begin
		next_s = s;
		ea = eff(req_i.addr, s.mem_pointer);
		ri = gpr_index(ea);
		cur = RESET_BYTE;
		// read mux; reserved holes fall through to zero
		unique case (ea)
			ADDR_IND:        cur = RESET_BYTE;
			ADDR_MEM_PTR:    cur = s.mem_pointer;
			ADDR_PCL:        cur = s.pc[7:0];
			ADDR_TABLE_PTR:  cur = s.table_pointer;
			ADDR_TABLE_HIGH: cur = s.table_high_byte;
			ADDR_PAGE_PTR:   cur = s.table_page_pointer;
			default:         cur = is_gpr(ea) ? s.ram[ri] : RESET_BYTE;
		endcase
		// bit ops are read-modify-write of the current value
		wv = req_i.wdata;
		if (req_i.op == OP_BIT) begin
			wv = cur;
			wv[req_i.bit_sel] = req_i.bit_val;
		end
		// table address for the current op
		if (req_i.last_page)
			taddr = {LAST_PAGE, s.table_pointer};
		else if (page_opt_i)
			taddr = {s.table_page_pointer[2:0], s.table_pointer};
		else
			taddr = {s.pc[10:8], s.table_pointer};
		next_s.vector = 1'b0;
		unique case (s.phase)
			ST_FETCH: begin
				next_s.rom_addr = s.pc;
				if (vector_taken(timer_ovf_i, timer_irq_en_i, stack_level_i)) begin
					next_s.pc = TIMER_VEC;
					next_s.phase = ST_VEC;
					next_s.vector = 1'b1;
				end else begin
					next_s.pc = 11'(s.pc + 11'h001);
					if (req_i.op == OP_READ)
						next_s.rdata = cur;
					// an indirect write onto the port itself does nothing
					if ((req_i.op == OP_WRITE || req_i.op == OP_BIT) && ea != ADDR_IND) begin
						unique case (ea)
							ADDR_MEM_PTR:    next_s.mem_pointer = wv;
							ADDR_TABLE_PTR:  next_s.table_pointer = wv;
							ADDR_PAGE_PTR:   next_s.table_page_pointer = wv;
							ADDR_TABLE_HIGH: next_s.table_high_byte = s.table_high_byte;
							default: begin
								if (is_gpr(ea))
									next_s.ram[ri] = wv;
							end
						endcase
					end
					if (req_i.op == OP_TABLE) begin
						next_s.rom_addr = taddr;
						next_s.dest = ea;
						next_s.busy = 1'b1;
						next_s.phase = ST_TABLE;
					end
				end
			end
			ST_TABLE: begin
				// second cycle: program port carries the table word
				next_s.table_high_byte = {1'b0, rom_data_i[14:8]};
				if (is_gpr(s.dest))
					next_s.ram[gpr_index(s.dest)] = rom_data_i[7:0];
				else if (s.dest == ADDR_TABLE_PTR)
					next_s.table_pointer = rom_data_i[7:0];
				else if (s.dest == ADDR_PAGE_PTR)
					next_s.table_page_pointer = rom_data_i[7:0];
				else if (s.dest == ADDR_MEM_PTR)
					next_s.mem_pointer = rom_data_i[7:0];
				next_s.rom_addr = s.pc;
				next_s.busy = 1'b0;
				next_s.phase = ST_FETCH;
			end
			ST_VEC: begin
				next_s.rom_addr = s.pc;
				next_s.phase = ST_FETCH;
			end
		endcase
	end

	// ========================================
	// registers; ram is not cleared so reset stays cheap
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			s <= next_s;
			s.phase <= ST_FETCH;
			s.pc <= RESET_VEC;
			s.rom_addr <= RESET_VEC;
			s.mem_pointer <= RESET_BYTE;
			s.table_pointer <= RESET_BYTE;
			s.table_high_byte <= RESET_BYTE;
			s.table_page_pointer <= RESET_BYTE;
			s.dest <= RESET_BYTE;
			s.rdata <= RESET_BYTE;
			s.busy <= 1'b0;
			s.vector <= 1'b0;
		end else begin
			s <= next_s;
		end
	end

	// outputs come straight from the state flops
	assign rom_addr_o = s.rom_addr;
	assign pc_o = s.pc;
	assign rdata_o = s.rdata;
	assign busy_o = s.busy;
	assign vector_o = s.vector;

	// ========================================
	// checks: reset and vectors
	// reset puts both the counter and the program port on the reset vector
	AST_RESET_PC: assert property (@(posedge clk_i) reset_i |=> pc_o == RESET_VEC)
		else $error("pc not at reset vector");

	AST_RESET_FETCH: assert property (@(posedge clk_i) reset_i |=> rom_addr_o == RESET_VEC)
		else $error("program port not at reset vector");

	// the vector pulse marks the cycle the counter holds the timer vector
	AST_TIMER_VEC: assert property (@(posedge clk_i) disable iff (reset_i)
		vector_o |-> pc_o == TIMER_VEC)
		else $error("timer vector wrong");

	// no vector with the stack full or the enable clear
	AST_NO_VEC_BLOCKED: assert property (@(posedge clk_i) disable iff (reset_i)
		(stack_level_i >= STACK_DEPTH) || !timer_irq_en_i |=> !vector_o)
		else $error("vector taken while blocked");

	AST_VEC_PULSE: assert property (@(posedge clk_i) disable iff (reset_i)
		vector_o |=> !vector_o)
		else $error("vector pulse longer than one cycle");

	// ========================================
	// checks: table unit
	// a table op that is taken raises busy on the next cycle
	AST_TABLE_TAKEN: assert property (@(posedge clk_i) disable iff (reset_i)
		s.phase == ST_FETCH && req_i.op == OP_TABLE
		&& !vector_taken(timer_ovf_i, timer_irq_en_i, stack_level_i)
		|=> busy_o)
		else $error("table read not started");

	AST_TWO_CYCLE: assert property (@(posedge clk_i) disable iff (reset_i)
		busy_o |=> !busy_o)
		else $error("table read not two cycles");

	// holding register only moves at the end of a table read
	AST_HIGH_BYTE_RO: assert property (@(posedge clk_i) disable iff (reset_i)
		!$past(busy_o) && !busy_o |=> $stable(s.table_high_byte))
		else $error("table high changed without table read");

	AST_HIGH_BYTE_TOP: assert property (@(posedge clk_i) disable iff (reset_i)
		s.table_high_byte[7] == 1'b0)
		else $error("table high top bit not zero");

	// upper bits of the fetched word land in the holding register
	AST_HIGH_BYTE_LOAD: assert property (@(posedge clk_i) disable iff (reset_i)
		busy_o |=> s.table_high_byte == {1'b0, $past(rom_data_i[14:8])})
		else $error("table high not loaded from word");

	// low byte of the fetched word lands at the chosen ram byte
	AST_LOW_BYTE_LOAD: assert property (@(posedge clk_i) disable iff (reset_i)
		busy_o && is_gpr(s.dest)
		|=> s.ram[gpr_index($past(s.dest))] == $past(rom_data_i[7:0]))
		else $error("table low byte not stored");

	// current page with the option off: counter page, pointer ignored
	AST_CURRENT_PAGE: assert property (@(posedge clk_i) disable iff (reset_i)
		s.phase == ST_FETCH && req_i.op == OP_TABLE && !req_i.last_page && !page_opt_i
		&& !vector_taken(timer_ovf_i, timer_irq_en_i, stack_level_i)
		|=> rom_addr_o == {$past(pc_o[10:8]), $past(s.table_pointer)})
		else $error("current page address wrong");

	// current page with the option on: page from the page pointer
	AST_PAGE_OPT: assert property (@(posedge clk_i) disable iff (reset_i)
		s.phase == ST_FETCH && req_i.op == OP_TABLE && !req_i.last_page && page_opt_i
		&& !vector_taken(timer_ovf_i, timer_irq_en_i, stack_level_i)
		|=> rom_addr_o == {$past(s.table_page_pointer[2:0]), $past(s.table_pointer)})
		else $error("page pointer address wrong");

	AST_LAST_PAGE: assert property (@(posedge clk_i) disable iff (reset_i)
		s.phase == ST_FETCH && req_i.op == OP_TABLE && req_i.last_page
		&& !vector_taken(timer_ovf_i, timer_irq_en_i, stack_level_i)
		|=> rom_addr_o == {LAST_PAGE, $past(s.table_pointer)})
		else $error("last page address wrong");

	// normal fetch picks up at the counter, already one past the address the table read displaced, which is not refetched
	AST_RESUME: assert property (@(posedge clk_i) disable iff (reset_i)
		busy_o |=> rom_addr_o == $past(pc_o))
		else $error("fetch not resumed");

	// ========================================
	// checks: data map
	AST_IND_ZERO: assert property (@(posedge clk_i) disable iff (reset_i)
		s.phase == ST_FETCH && req_i.op == OP_READ && ea == ADDR_IND
		&& !vector_taken(timer_ovf_i, timer_irq_en_i, stack_level_i)
		|=> rdata_o == RESET_BYTE)
		else $error("indirect self read not zero");

	// direct reads above the ram window come back zero
	AST_UNUSED_ZERO: assert property (@(posedge clk_i) disable iff (reset_i)
		s.phase == ST_FETCH && req_i.op == OP_READ && req_i.addr >= GPR_BASE + 8'(GPR_DEPTH)
		&& !vector_taken(timer_ovf_i, timer_irq_en_i, stack_level_i)
		|=> rdata_o == RESET_BYTE)
		else $error("unused location not zero");

	// plain writes to general ram land unless a vector is taken or a table read holds the cycle
	AST_GPR_WRITE: assert property (@(posedge clk_i) disable iff (reset_i)
		s.phase == ST_FETCH && req_i.op == OP_WRITE && is_gpr(ea)
		&& !vector_taken(timer_ovf_i, timer_irq_en_i, stack_level_i)
		|=> s.ram[gpr_index($past(ea))] == $past(req_i.wdata))
		else $error("general ram write lost");

	// bit ops leave the protected holding register alone
	AST_BIT_PROTECT: assert property (@(posedge clk_i) disable iff (reset_i)
		s.phase == ST_FETCH && req_i.op == OP_BIT && ea == ADDR_TABLE_HIGH
		&& !vector_taken(timer_ovf_i, timer_irq_en_i, stack_level_i)
		|=> $stable(s.table_high_byte))
		else $error("bit op changed protected register");

	// ========================================
	// main scenarios worth seeing
	COV_TABLE: cover property (@(posedge clk_i) busy_o ##1 !busy_o);
	COV_VEC: cover property (@(posedge clk_i) vector_o);
	COV_PAGE: cover property (@(posedge clk_i) page_opt_i && busy_o);
	COV_LAST_PAGE: cover property (@(posedge clk_i) s.phase == ST_FETCH && req_i.op == OP_TABLE && req_i.last_page);
	COV_IND_SELF: cover property (@(posedge clk_i) s.phase == ST_FETCH && req_i.op == OP_READ && ea == ADDR_IND);
endmodule : table_map
`default_nettype wire

// File: sim/program_table_read_and_data_map_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module program_table_read_and_data_map_tb_top
	import table_map_pkg::*;
;
	typedef struct packed {logic [7:0] waddr; logic [7:0] wdata; logic [7:0] raddr; logic [7:0] exp;} row_t;
	logic        clk_i, reset_i, page_opt_i, timer_ovf_i, timer_irq_en_i, busy_o, vector_o;
	logic [2:0]  stack_level_i;
	req_t        req_i;
	logic [14:0] rom_data_i;
	logic [10:0] rom_addr_o, pc_o;
	logic [7:0]  rdata_o;
	int          n_fail, n_tests;
	// ========================================
	// write then read rows: write address, data, read address, expected
	row_t rows [8] = '{
		'{8'h20, 8'h5a, 8'h20, 8'h5a},
		'{8'h08, 8'hff, 8'h08, 8'h00},
		'{8'h90, 8'h77, 8'h90, 8'h00},
		'{8'h07, 8'h06, 8'h07, 8'h06},
		'{8'h1f, 8'h05, 8'h1f, 8'h05},
		'{8'h01, 8'h21, 8'h01, 8'h21},
		'{8'h00, 8'h3c, 8'h21, 8'h3c},
		'{8'h01, 8'h00, 8'h00, 8'h00}
	};
	// program memory image: both halves depend on the address, so a wrong page shows
	function automatic logic [14:0] rom_word(input logic [10:0] a);
		return {a[10:4], a[7:0]} ^ 15'h5a5a;
	endfunction : rom_word
	assign rom_data_i = rom_word(rom_addr_o);
	table_map dut_u (.clk_i(clk_i), .reset_i(reset_i), .req_i(req_i), .page_opt_i(page_opt_i),
		.timer_ovf_i(timer_ovf_i), .timer_irq_en_i(timer_irq_en_i), .stack_level_i(stack_level_i),
		.rom_data_i(rom_data_i), .rom_addr_o(rom_addr_o), .pc_o(pc_o), .rdata_o(rdata_o),
		.busy_o(busy_o), .vector_o(vector_o));
	// ========================================
	// shared tasks
	task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// one request held for one edge, then dropped
	task automatic issue(input op_t op, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		#1 req_i = '{op: op, addr: a, wdata: d, bit_sel: 3'h0, bit_val: 1'b1, last_page: 1'b0};
		@(posedge clk_i);
		#1 req_i.op = OP_NONE;
	endtask : issue
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		issue(OP_READ, a, 8'h00);
		chk("rdata", {3'h0, exp}, {3'h0, rdata_o});
	endtask : rd
	// table pointer is 06h, page pointer 05h when called
	task automatic tbl(input logic last);
		logic [10:0] ea;
		logic [14:0] w;
		@(posedge clk_i);
		#1 req_i = '{op: OP_TABLE, addr: 8'h22, wdata: 8'h00, bit_sel: 3'h0, bit_val: 1'b0, last_page: last};
		ea = last ? {LAST_PAGE, 8'h06} : page_opt_i ? {3'h5, 8'h06} : {pc_o[10:8], 8'h06};
		w = rom_word(ea);
		@(posedge clk_i);
		#1 req_i.op = OP_NONE;
		chk("rom_addr", ea, rom_addr_o);
		chk("busy", 11'h1, {10'h0, busy_o});
		@(posedge clk_i);
		#1 chk("busy", 11'h0, {10'h0, busy_o});
		rd(8'h22, w[7:0]);
		rd(ADDR_TABLE_HIGH, {1'b0, w[14:8]});
	endtask : tbl
	task automatic vec(input logic en, input logic [2:0] lvl, input logic expv);
		@(posedge clk_i);
		#1 {timer_ovf_i, timer_irq_en_i, stack_level_i} = {1'b1, en, lvl};
		@(posedge clk_i);
		#1 timer_ovf_i = 1'b0;
		chk("vector", {10'h0, expv}, {10'h0, vector_o});
		if (expv)
			chk("pc", TIMER_VEC, pc_o);
	endtask : vec
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : tally_and_finish
	// ========================================
	// clock and watchdog; the run needs well under a thousand cycles
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	initial begin
		#100000;
		n_fail++;
		tally_and_finish();
	end
	// ========================================
	// main sequence
	initial begin
		{reset_i, page_opt_i, timer_ovf_i, timer_irq_en_i, stack_level_i} = {1'b1, 6'h0};
		req_i = '{op: OP_NONE, default: '0};
		repeat (20) @(posedge clk_i);
		#1 reset_i = 1'b0;
		chk("pc", RESET_VEC, pc_o);
		for (int i = 0; i < 8; i++) begin
			issue(OP_WRITE, rows[i].waddr, rows[i].wdata);
			rd(rows[i].raddr, rows[i].exp);
		end
		tbl(1'b0);
		page_opt_i = 1'b1;
		tbl(1'b0);
		tbl(1'b1);
		page_opt_i = 1'b0;
		// bit set in place, then on the protected holding register
		issue(OP_BIT, 8'h21, 8'h00);
		rd(8'h21, 8'h3d);
		issue(OP_BIT, ADDR_TABLE_HIGH, 8'h00);
		rd(ADDR_TABLE_HIGH, 8'h2a);
		// vector taken with the enable set and room on the stack, then blocked by a full stack and by a clear enable
		vec(1'b1, 3'h0, 1'b1);
		vec(1'b1, STACK_DEPTH, 1'b0);
		vec(1'b0, 3'h0, 1'b0);
		@(posedge clk_i);
		#1 reset_i = 1'b1;
		@(posedge clk_i);
		#1 reset_i = 1'b0;
		chk("pc", RESET_VEC, pc_o);
		rd(ADDR_TABLE_PTR, 8'h00);
		tally_and_finish();
	end
endmodule : program_table_read_and_data_map_tb_top
`default_nettype wire
